// ===== hdl/tcd_top.sv
// threshold comparators, debounce filters and their registers
// assumes register strobes and samples come from logic on clk
module tcd_top #(
   parameter int STEP_CYCLES = tcd_pkg::STEP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [tcd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [tcd_pkg::DATA_W-1:0] reg_wdata,
   output logic [tcd_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // samples
   input wire logic [tcd_pkg::LEVEL_W-1:0] adc_sample,
   input wire logic adc_valid,
   // comparator modes, two bits per path
   input wire logic [2*tcd_pkg::NUM_PATHS-1:0] comparator_mode,
   // path outputs
   output logic digital_output_pin,
   output logic warning_a_out,
   output logic warning_b_out,
   output logic warning_c_out,
   output logic [tcd_pkg::NUM_PATHS-1:0] comparator_state,
   output logic [tcd_pkg::NUM_PATHS-2:0] warning_rise
);
   localparam int STEP_W = $clog2(STEP_CYCLES + 1);
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

   // register storage
   logic [tcd_pkg::DATA_W-1:0] regs_reg [tcd_pkg::NUM_REGS];
   logic [tcd_pkg::DATA_W-1:0] rdata_reg;
   logic rvalid_reg;

   // address decode
   wire addr_hit;
   wire [tcd_pkg::ADDR_W-1:0] reg_index;
   wire [tcd_pkg::NUM_REGS-1:0] wr_sel;
   wire [tcd_pkg::DATA_W-1:0] rd_mux;

   // step timer
   logic [STEP_W-1:0] step_cnt_reg;
   logic [STEP_W-1:0] step_cnt_next;
   wire step_tick;

   // comparator and filter paths
   logic [tcd_pkg::NUM_PATHS-1:0] cmp_reg;
   logic [tcd_pkg::NUM_PATHS-1:0] cmp_next;
   wire [tcd_pkg::NUM_PATHS-1:0] path_enable;
   wire [tcd_pkg::NUM_PATHS-1:0] gated;
   wire [tcd_pkg::NUM_FILTERS-1:0] filtered;
   logic [tcd_pkg::NUM_PATHS-2:0] warn_prev_reg;
   wire [tcd_pkg::NUM_PATHS-2:0] warn_now;

   // ---- register port ----
   // offsets are contiguous, so one subtract gives the index
   assign addr_hit = (reg_addr >= tcd_pkg::OFS_BINARY_LEVELS)
      && (reg_addr <= tcd_pkg::OFS_WARN_B_CONFIG);
   assign reg_index = reg_addr - tcd_pkg::OFS_BINARY_LEVELS;
   assign rd_mux = addr_hit ? regs_reg[reg_index[2:0]] : '0;

   genvar r;
   generate
      for (r = 0; r < tcd_pkg::NUM_REGS; r++) begin : g_reg
         localparam logic [15:0] WMASK = (r < tcd_pkg::NUM_LEVEL_REGS)
            ? tcd_pkg::WMASK_LEVELS : tcd_pkg::WMASK_CONFIG;
         assign wr_sel[r] = reg_wr && addr_hit
            && (reg_index == tcd_pkg::ADDR_W'(r));

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               regs_reg[r] <= tcd_pkg::REG_RESET[r]; // RL3
            end else if (wr_sel[r]) begin
               // masked bits keep their value, so reserved reads zero
               regs_reg[r] <= (reg_wdata & WMASK) | (regs_reg[r] & ~WMASK); // RL16
            end
         end
      end
   endgenerate

   // read data holds until the next read; unmapped offsets read zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_rd;
         if (reg_rd) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // ---- step timer ----
   // one free-running timer shared by all filters; a step may fall
   // anywhere inside the first period after a change
   assign step_tick = (step_cnt_reg == STEP_LAST); // RL9

   always_comb begin
      step_cnt_next = step_cnt_reg + 1'b1;
      if (step_tick) begin
         step_cnt_next = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step_cnt_reg <= '0;
      end else begin
         step_cnt_reg <= step_cnt_next;
      end
   end

   // ---- comparators ----
   genvar p;
   generate
      for (p = 0; p < tcd_pkg::NUM_PATHS; p++) begin : g_cmp
         wire [tcd_pkg::LEVEL_W-1:0] low_level;
         wire [tcd_pkg::LEVEL_W-1:0] high_level;
         wire above_high;
         wire at_or_below_low;
         wire tcd_pkg::tcd_cmp_mode_e mode;

         assign low_level = regs_reg[p][tcd_pkg::LOW_LSB +: tcd_pkg::LEVEL_W];
         assign high_level = regs_reg[p][tcd_pkg::HIGH_LSB +: tcd_pkg::LEVEL_W];
         assign above_high = (adc_sample > high_level); // RL2
         assign at_or_below_low = (adc_sample <= low_level); // RL1
         assign mode = tcd_pkg::tcd_cmp_mode_e'(comparator_mode[2*p +: 2]);

         always_comb begin
            cmp_next[p] = cmp_reg[p];
            if (adc_valid) begin
               unique case (mode) // RL15
                  tcd_pkg::TCD_MODE_HYST: begin
                     if (above_high) begin
                        cmp_next[p] = 1'b1; // RL2
                     end else if (at_or_below_low) begin
                        cmp_next[p] = 1'b0; // RL1
                     end
                  end
                  tcd_pkg::TCD_MODE_MID: begin
                     cmp_next[p] = !above_high && !at_or_below_low
                        && (adc_sample != high_level);
                  end
                  tcd_pkg::TCD_MODE_GT: begin
                     cmp_next[p] = above_high;
                  end
                  tcd_pkg::TCD_MODE_LT: begin
                     cmp_next[p] = !above_high;
                  end
               endcase
            end
         end

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               cmp_reg[p] <= 1'b0;
            end else begin
               cmp_reg[p] <= cmp_next[p];
            end
         end
      end
   endgenerate

   // ---- enables ----
   // warning C has no config register here, so it stays enabled
   generate
      for (p = 0; p < tcd_pkg::NUM_FILTERS; p++) begin : g_en
         assign path_enable[p] =
            regs_reg[tcd_pkg::NUM_LEVEL_REGS + p][tcd_pkg::ENABLE_BIT]; // RL7
      end
   endgenerate
   assign path_enable[tcd_pkg::PATH_WARN_C] = 1'b1;
   assign gated = cmp_reg & path_enable; // RL7

   // ---- debounce filters ----
   genvar f;
   generate
      for (f = 0; f < tcd_pkg::NUM_FILTERS; f++) begin : g_filt
         tcd_filter_if fif ();

         assign fif.raw = gated[f];
         assign fif.step = step_tick;
         assign fif.length = regs_reg[tcd_pkg::NUM_LEVEL_REGS + f]
            [tcd_pkg::LENGTH_LSB +: tcd_pkg::LEN_W]; // RL9
         assign fif.count_down_mode = regs_reg[tcd_pkg::NUM_LEVEL_REGS + f]
            [tcd_pkg::DIRECTION_BIT]; // RL8
         assign filtered[f] = fif.filtered;

         tcd_debounce u_debounce (
            .clk(clk),
            .rst_b(rst_b),
            .port(fif.filt)
         );
      end
   endgenerate

   // ---- outputs ----
   assign digital_output_pin = filtered[tcd_pkg::PATH_BINARY];
   assign warning_a_out = filtered[tcd_pkg::PATH_WARN_A];
   assign warning_b_out = filtered[tcd_pkg::PATH_WARN_B];
   assign warning_c_out = gated[tcd_pkg::PATH_WARN_C];
   assign comparator_state = cmp_reg;

   // low-to-high events on the warning outputs, one cycle each
   assign warn_now = {warning_c_out, warning_b_out, warning_a_out};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warn_prev_reg <= '0;
      end else begin
         warn_prev_reg <= warn_now;
      end
   end

   assign warning_rise = warn_now & ~warn_prev_reg;
endmodule

// ===== pkg/tcd_pkg.sv
// constants, field layout, reset values and modes of the threshold block
// assumes one 100 MHz clock and a decoded 16-bit register port
// Operation
// RL1 - sample at or below low level clears output
// RL2 - sample above high level sets output
// RL3 - binary levels reset low 0x5A, high 0xAA
// RL4 - warning A levels reset both to 0xCC
// RL5 - warning B levels reset 0x5A and 0x88
// RL6 - warning C levels reset both to 0x2D
// RL7 - binary enable clear forces comparator low; here it gates only the filter input and comparator_state stays high
// RL8 - bit 14 selects up/down, else up/clear
// RL9 - filter length counts 20 us periods
// RL10 - pulses shorter than length leave output unchanged
// RL11 - zero length bypasses filter, no latency
// RL12 - binary config resets to 0x0096
// RL13 - warning A config resets to 0x80FA
// RL14 - warning B config resets to 0x80FA
// RL15 - two-bit field picks hysteretic, midrange, GT, LT
// RL16 - reserved bit 13 reads zero, ignores writes
// RL17 - count while differing, toggle at length
package tcd_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int LEVEL_W = 8;
   localparam int LEN_W = 13;
   localparam int NUM_PATHS = 4;
   localparam int NUM_FILTERS = 3;
   localparam int NUM_REGS = 7;
   localparam int NUM_LEVEL_REGS = 4;

   // path order inside every per-path vector; warning_rise holds only warnings A to C, from bit 0
   localparam int PATH_BINARY = 0;
   localparam int PATH_WARN_A = 1;
   localparam int PATH_WARN_B = 2;
   localparam int PATH_WARN_C = 3;

   // register offsets
   localparam logic [9:0] OFS_BINARY_LEVELS = 10'h003;
   localparam logic [9:0] OFS_WARN_A_LEVELS = 10'h004;
   localparam logic [9:0] OFS_WARN_B_LEVELS = 10'h005;
   localparam logic [9:0] OFS_WARN_C_LEVELS = 10'h006;
   localparam logic [9:0] OFS_BINARY_CONFIG = 10'h007;
   localparam logic [9:0] OFS_WARN_A_CONFIG = 10'h008;
   localparam logic [9:0] OFS_WARN_B_CONFIG = 10'h009;

   // field positions
   localparam int LOW_LSB = 8;
   localparam int HIGH_LSB = 0;
   localparam int ENABLE_BIT = 15;
   localparam int DIRECTION_BIT = 14;
   localparam int RESERVED_BIT = 13;
   localparam int LENGTH_LSB = 0;

   // reset values
   localparam logic [15:0] RST_BINARY_LEVELS = 16'h5AAA; // RL3
   localparam logic [15:0] RST_WARN_A_LEVELS = 16'hCCCC; // RL4
   localparam logic [15:0] RST_WARN_B_LEVELS = 16'h5A88; // RL5
   localparam logic [15:0] RST_WARN_C_LEVELS = 16'h2D2D; // RL6
   localparam logic [15:0] RST_BINARY_CONFIG = 16'h0096; // RL12
   localparam logic [15:0] RST_WARN_A_CONFIG = 16'h80FA; // RL13
   localparam logic [15:0] RST_WARN_B_CONFIG = 16'h80FA; // RL14
   localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
      RST_WARN_B_CONFIG, RST_WARN_A_CONFIG, RST_BINARY_CONFIG,
      RST_WARN_C_LEVELS, RST_WARN_B_LEVELS, RST_WARN_A_LEVELS,
      RST_BINARY_LEVELS};

   // writable bits
   localparam logic [15:0] WMASK_LEVELS = 16'hFFFF;
   localparam logic [15:0] WMASK_CONFIG = 16'hDFFF;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_TIME_US = 20;
   localparam int STEP_CYCLES = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      TCD_MODE_HYST = 2'b00,
      TCD_MODE_MID = 2'b01,
      TCD_MODE_GT = 2'b10,
      TCD_MODE_LT = 2'b11
   } tcd_cmp_mode_e;
endpackage

// ===== pkg/tcd_filter_if.sv
// signals between the top and one debounce filter
// assumes all members change on the top's clock
interface tcd_filter_if;
   logic [tcd_pkg::LEN_W-1:0] length;
   logic count_down_mode;
   logic step;
   logic raw;
   logic filtered;
   modport ctrl (output length, output count_down_mode, output step, output raw,
      input filtered);
   modport filt (input length, input count_down_mode, input step, input raw,
      output filtered);
endinterface

// ===== hdl/tcd_debounce.sv
// one debounce filter counting whole steps
// assumes step is a one-cycle pulse every step period
module tcd_debounce (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // configuration and data
   tcd_filter_if.filt port
);
   logic state_reg;
   logic state_next;
   logic [tcd_pkg::LEN_W-1:0] cnt_reg;
   logic [tcd_pkg::LEN_W-1:0] cnt_next;
   wire bypass;
   wire differs;
   wire [tcd_pkg::LEN_W:0] cnt_inc;
   wire reached;

   assign bypass = (port.length == '0);
   assign differs = (port.raw != state_reg);
   assign cnt_inc = {1'b0, cnt_reg} + {{tcd_pkg::LEN_W{1'b0}}, 1'b1};
   assign reached = (cnt_inc >= {1'b0, port.length});

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (bypass) begin
         // keeps state aligned so leaving bypass causes no toggle
         state_next = port.raw; // RL11
         cnt_next = '0;
      end else if (port.step) begin
         if (differs) begin
            if (reached) begin
               state_next = ~state_reg; // RL17
               cnt_next = '0;
            end else begin
               cnt_next = cnt_inc[tcd_pkg::LEN_W-1:0]; // RL10
            end
         end else if (port.count_down_mode) begin
            cnt_next = (cnt_reg == '0) ? cnt_reg : cnt_reg - 1'b1; // RL8
         end else begin
            cnt_next = '0; // RL17
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // zero length passes straight through
   assign port.filtered = bypass ? port.raw : state_reg; // RL11
endmodule

// ===== test/tcd_top_properties.sv
// assertions on the threshold block top ports
// assumes binding onto tcd_top; shadows follow binary level and binary config writes
module tcd_top_properties #(
   parameter int STEP_CYCLES = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   // samples and outputs
   input wire logic [7:0] adc_sample,
   input wire logic adc_valid,
   input wire logic [7:0] comparator_mode,
   input wire logic digital_output_pin,
   input wire logic warning_a_out,
   input wire logic warning_b_out,
   input wire logic warning_c_out,
   input wire logic [3:0] comparator_state,
   input wire logic [2:0] warning_rise
);
   logic [15:0] lvl_reg;
   logic [15:0] cfg_reg;
   int diff_cnt;
   wire logic gate_in = cfg_reg[15] & comparator_state[0];
   wire logic hyst = comparator_mode[1:0] == 2'h0;
   wire logic bypass = cfg_reg[12:0] == 13'h0000;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lvl_reg <= 16'h5AAA;
         cfg_reg <= 16'h0096;
         diff_cnt <= 0;
      end else begin
         if (reg_wr && reg_addr == 10'h003) begin
            lvl_reg <= reg_wdata;
         end
         if (reg_wr && reg_addr == 10'h007) begin
            cfg_reg <= reg_wdata & 16'hDFFF;
         end
         diff_cnt <= (gate_in != digital_output_pin) ? diff_cnt + 1 : 0;
      end
   end
   AST_CMP_SET: assert property (adc_valid && hyst && adc_sample > lvl_reg[7:0]
      |=> comparator_state[0]) else $error("comparator not set above high level");
   AST_CMP_CLR: assert property (adc_valid && hyst && adc_sample <= lvl_reg[15:8]
      |=> !comparator_state[0]) else $error("comparator not cleared at low level");
   AST_CMP_LT: assert property (adc_valid && comparator_mode[1:0] == 2'h3
      && adc_sample <= lvl_reg[7:0] |=> comparator_state[0]) else $error("lt mode wrong");
   AST_CMP_HOLD: assert property (!adc_valid |=> $stable(comparator_state))
      else $error("comparator moved without a sample");
   AST_EN_GATE: assert property (!cfg_reg[15] && bypass |-> !digital_output_pin)
      else $error("disabled path drives output high");
   AST_BYPASS: assert property (bypass |-> digital_output_pin == gate_in)
      else $error("zero length output not following comparator");
   AST_RSV_BIT: assert property (reg_rd && reg_addr inside {[10'h007:10'h009]}
      |=> reg_rvalid && !reg_rdata[13]) else $error("reserved bit reads one");
   AST_READBACK: assert property (reg_rd && reg_addr == 10'h003
      |=> reg_rdata == $past(lvl_reg)) else $error("level register readback wrong");
   // up/down keeps history, so the length bound holds only in up/clear
   AST_FILT_SHORT: assert property (!bypass && !cfg_reg[14] && $stable(cfg_reg)
      && $changed(digital_output_pin)
      |-> diff_cnt >= (int'(cfg_reg[12:0]) - 1) * STEP_CYCLES - 1)
      else $error("filter passed a short pulse");
   cover property (reg_wr && reg_addr == 10'h007);
   cover property ($rose(digital_output_pin) && !bypass);
   cover property ($changed(comparator_state));
endmodule
bind tcd_top tcd_top_properties #(.STEP_CYCLES(STEP_CYCLES)) u_tcd_top_properties (
   .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .adc_sample(adc_sample), .adc_valid(adc_valid), .comparator_mode(comparator_mode),
   .digital_output_pin(digital_output_pin), .warning_a_out(warning_a_out),
   .warning_b_out(warning_b_out), .warning_c_out(warning_c_out),
   .comparator_state(comparator_state), .warning_rise(warning_rise));

// ===== test/tb_top.sv
// self-checking bench for the threshold block
// assumes tcd_top with a 4-cycle step and its checker bound in
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, reg_wr, reg_rd, reg_rvalid, adc_valid;
   logic digital_output_pin, warning_a_out, warning_b_out, warning_c_out;
   logic [9:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [7:0] adc_sample, comparator_mode;
   logic [3:0] comparator_state;
   logic [2:0] warning_rise;
   int fails, comparisons, cycles;
   logic [15:0] rst_val [7] = '{16'h5AAA, 16'hCCCC, 16'h5A88, 16'h2D2D, 16'h0096,
      16'h80FA, 16'h80FA};
   logic [7:0] lv_in [4] = '{8'hCD, 8'hCC, 8'h5B, 8'h2D};
   logic [3:0] lv_exp [4] = '{4'hF, 4'hD, 4'hD, 4'h0};
   logic [1:0] md [11] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
   logic [7:0] md_in [11] = '{8'hAB, 8'hAA, 8'hAA, 8'hAB, 8'h80, 8'h5A, 8'h5B, 8'hAA,
      8'hAB, 8'h5B, 8'h5A};
   logic [10:0] md_exp = 11'h355;
   tcd_top #(.STEP_CYCLES(4)) u_tcd_top (
      .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .adc_sample(adc_sample), .adc_valid(adc_valid), .comparator_mode(comparator_mode),
      .digital_output_pin(digital_output_pin), .warning_a_out(warning_a_out),
      .warning_b_out(warning_b_out), .warning_c_out(warning_c_out),
      .comparator_state(comparator_state), .warning_rise(warning_rise));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task chk_bits(input string n, input logic [3:0] e, input logic [3:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(negedge clk);
      reg_wr = 1'h0;
   endtask
   task rd(input logic [9:0] a, input logic [15:0] e);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'h1;
      @(negedge clk);
      reg_rd = 1'h0;
      chk_word("rvalid", 16'h0001, {15'h0000, reg_rvalid});
      chk_word("rdata", e, reg_rdata);
   endtask
   // one sample, then n idle cycles; spacing to the next sample is n+2
   task smp(input logic [7:0] v, input int n);
      @(negedge clk);
      adc_sample = v;
      adc_valid = 1'h1;
      @(negedge clk);
      adc_valid = 1'h0;
      repeat (n) @(negedge clk);
   endtask
   task pin(input logic e);
      chk_bits("dout", {3'h0, e}, {3'h0, digital_output_pin});
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("ERROR timeout expected finish seen hang");
         conclude();
      end
   end
   initial begin
      {rst_b, reg_wr, reg_rd, adc_valid} = 4'h0;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      adc_sample = 8'h00;
      comparator_mode = 8'h00;
      repeat (20) @(negedge clk);
      rst_b = 1'h1;
      for (int i = 0; i < 7; i++) rd(10'(i + 3), rst_val[i]);
      rd(10'h00A, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         smp(lv_in[i], 0);
         chk_bits("state", lv_exp[i], comparator_state);
         chk_bits("warn_c", {3'h0, lv_exp[i][3]}, {3'h0, warning_c_out});
         chk_bits("rise", (i == 0) ? 4'h4 : 4'h0, {1'h0, warning_rise});
         pin(1'h0);
      end
      $display("test reset levels done");
      for (int a = 7; a < 10; a++) begin
         wr(10'(a), 16'hFFFF);
         rd(10'(a), 16'hDFFF);
      end
      $display("test reserved bit done");
      wr(10'h007, 16'h8000);
      for (int i = 0; i < 11; i++) begin
         comparator_mode = {6'h00, md[i]};
         smp(md_in[i], 0);
         chk_bits("state", {3'h0, md_exp[i]}, comparator_state & 4'h1);
         pin(md_exp[i]);
      end
      comparator_mode = 8'h00;
      wr(10'h003, 16'h1020);
      rd(10'h003, 16'h1020);
      smp(8'h21, 0);
      pin(1'h1);
      smp(8'h10, 0);
      pin(1'h0);
      wr(10'h007, 16'h0000);
      smp(8'hFF, 0);
      chk_bits("state", 4'h1, comparator_state & 4'h1);
      pin(1'h0);
      $display("test modes done");
      wr(10'h007, 16'h8003);
      smp(8'h00, 20);
      pin(1'h0);
      smp(8'hFF, 2);
      smp(8'h00, 12);
      pin(1'h0);
      smp(8'hFF, 4);
      pin(1'h0);
      repeat (10) @(negedge clk);
      pin(1'h1);
      smp(8'h00, 20);
      // two steps up, one down, two up: only up/down reaches three
      for (int m = 0; m < 2; m++) begin
         wr(10'h007, m ? 16'hC003 : 16'h8003);
         smp(8'hFF, 6);
         smp(8'h00, 2);
         smp(8'hFF, 6);
         smp(8'h00, 0);
         pin(m[0]);
         smp(8'h00, 20);
      end
      $display("test filter done");
      // warning A bypassed and enabled, warning B disabled
      wr(10'h008, 16'h8000);
      wr(10'h009, 16'h0000);
      smp(8'hFF, 0);
      chk_bits("warn_ab", 4'h1, {2'h0, warning_b_out, warning_a_out});
      chk_bits("rise", 4'h5, {1'h0, warning_rise});
      @(negedge clk);
      chk_bits("rise", 4'h0, {1'h0, warning_rise});
      $display("test warnings done");
      conclude();
   end
endmodule
